//--- design/bfi_cfg.svh
// Purpose : Constants for the bit field insert unit
// Assumes : 32-bit operands, one result per request
// Notes   : Opcode, size and field constants
`ifndef BFI_CFG_SVH
`define BFI_CFG_SVH

`define BFI_OP_BYTE    8'hcb
`define BFI_OP_WORD    8'hc8
`define BFI_OP_HALF    8'hca
`define BFI_DATA_W     32
`define BFI_SEL_W      5
`define BFI_BYTE_BITS  6'h08
`define BFI_HALF_BITS  6'h10
`define BFI_WORD_BITS  6'h20
`define BFI_BYTE_MASK  32'h0000_00ff
`define BFI_HALF_MASK  32'h0000_ffff
`define BFI_WORD_MASK  32'hffff_ffff
`define BFI_BYTE_MSB   5'h07
`define BFI_HALF_MSB   5'h0f
`define BFI_WORD_MSB   5'h1f

`endif

//--- design/bfi_pkg.sv
// Purpose : Types for the bit field insert unit
// Assumes : Constants come from bfi_cfg.svh
// Notes   : Request, answer and state carriers
`include "bfi_cfg.svh"

package bfi_pkg;

   typedef enum logic [1:0] {
      BFI_SZ_NONE,
      BFI_SZ_BYTE,
      BFI_SZ_HALF,
      BFI_SZ_WORD
   } bfi_size_t;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [31:0] width;
      logic [31:0] offset;
      logic [31:0] src;
      logic [31:0] dst;
      logic        dst_literal;
   } bfi_req_t;

   typedef struct packed {
      logic [31:0] result;
      logic        flag_n;
      logic        flag_z;
      logic        flag_c;
      logic        flag_v;
   } bfi_res_t;

   typedef struct packed {
      bfi_res_t res;
      logic     done;
      logic     illegal;
   } bfi_state_t;

endpackage : bfi_pkg

//--- design/bfi_insert_unit.sv
// Purpose : Insert-field datapath for byte, halfword and word sizes
// Assumes : Decode presents one request per valid cycle
// Notes   : Answer registered one cycle after the request
//
// Contract
// - Byte opcode selects insert_field_byte with an 8-bit destination.
// - Word opcode selects insert_field_word with a 32-bit destination.
// - Field chosen by offset and width is overwritten from source bits.
// - Literal or immediate destination raises illegal operand, no insertion.
// - N is destination MSB, Z on zero, C cleared, V only on overflow.
// - Only low five bits of width and offset are used.
// - Field past bit 31 wraps around to destination bit 0.
// - Width+1 source bits from bit 0 land at offset.
// - Short destinations: bits beyond stay unchanged, V set on overrun.
`timescale 1ns/1ps
`include "bfi_cfg.svh"
`default_nettype none

module bfi_insert_unit #(
   parameter logic [7:0] HALF_OPCODE = `BFI_OP_HALF,
   parameter int         DATA_W      = `BFI_DATA_W
) (
   input  wire logic              clk_sys_in,
   input  wire logic              rst_n_in,
   input  wire logic              req_valid_in,
   input  wire bfi_pkg::bfi_req_t req_in,
   output var  bfi_pkg::bfi_res_t res_out,
   output logic                   done_out,
   output logic                   illegal_out
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   if (DATA_W != `BFI_DATA_W)
   begin : g_bad_width
      $error("Only 32-bit operands are supported");
   end
   if (HALF_OPCODE == `BFI_OP_BYTE || HALF_OPCODE == `BFI_OP_WORD)
   begin : g_bad_opcode
      $error("Halfword opcode clashes with another size");
   end

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic bfi_pkg::bfi_size_t decode_size(input logic [7:0] op);
      bfi_pkg::bfi_size_t sz;
      sz = bfi_pkg::BFI_SZ_NONE;
      if (op == `BFI_OP_BYTE)
         sz = bfi_pkg::BFI_SZ_BYTE;
      else if (op == `BFI_OP_WORD)
         sz = bfi_pkg::BFI_SZ_WORD;
      else if (op == HALF_OPCODE)
         sz = bfi_pkg::BFI_SZ_HALF;
      return sz;
   endfunction : decode_size

   function automatic logic [31:0] size_mask(input bfi_pkg::bfi_size_t sz);
      logic [31:0] m;
      m = `BFI_WORD_MASK;
      case (sz)
         bfi_pkg::BFI_SZ_BYTE: m = `BFI_BYTE_MASK;
         bfi_pkg::BFI_SZ_HALF: m = `BFI_HALF_MASK;
         default:              m = `BFI_WORD_MASK;
      endcase
      return m;
   endfunction : size_mask

   function automatic logic [4:0] size_msb(input bfi_pkg::bfi_size_t sz);
      logic [4:0] b;
      b = `BFI_WORD_MSB;
      case (sz)
         bfi_pkg::BFI_SZ_BYTE: b = `BFI_BYTE_MSB;
         bfi_pkg::BFI_SZ_HALF: b = `BFI_HALF_MSB;
         default:              b = `BFI_WORD_MSB;
      endcase
      return b;
   endfunction : size_msb

   function automatic logic [5:0] size_bits(input bfi_pkg::bfi_size_t sz);
      logic [5:0] n;
      n = `BFI_WORD_BITS;
      case (sz)
         bfi_pkg::BFI_SZ_BYTE: n = `BFI_BYTE_BITS;
         bfi_pkg::BFI_SZ_HALF: n = `BFI_HALF_BITS;
         default:              n = `BFI_WORD_BITS;
      endcase
      return n;
   endfunction : size_bits

   function automatic logic [31:0] rotl(input logic [31:0] v, input logic [4:0] s);
      logic [63:0] d;
      d = {v, v} << s;
      return d[63:32];
   endfunction : rotl

   function automatic logic [31:0] low_ones(input logic [4:0] w);
      logic [32:0] t;
      t = (33'h0_0000_0002 << w) - 33'h0_0000_0001;
      return t[31:0];
   endfunction : low_ones

   // ----------------------------------------------------------------
   // Datapath
   // ----------------------------------------------------------------
   bfi_pkg::bfi_state_t st_r;
   bfi_pkg::bfi_state_t st_nxt;

   logic [4:0]         fld_w;
   logic [4:0]         fld_o;
   bfi_pkg::bfi_size_t req_sz;
   logic [31:0]        fld_mask;
   logic [31:0]        fld_data;
   logic [31:0]        keep_mask;
   logic [31:0]        merged;
   logic [5:0]         fld_end;

   always_comb
   begin
      fld_w     = req_in.width[`BFI_SEL_W-1:0];
      fld_o     = req_in.offset[`BFI_SEL_W-1:0];
      req_sz    = decode_size(req_in.opcode);
      fld_mask  = rotl(low_ones(fld_w), fld_o);
      fld_data  = rotl(req_in.src & low_ones(fld_w), fld_o);
      keep_mask = fld_mask & size_mask(req_sz);
      merged    = (req_in.dst & ~keep_mask) | (fld_data & keep_mask);
      fld_end   = {1'b0, fld_w} + {1'b0, fld_o} + 6'h01;
   end

   // ----------------------------------------------------------------
   // State update
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt         = st_r;
      st_nxt.done    = 1'b0;
      st_nxt.illegal = 1'b0;
      if (req_valid_in && req_sz != bfi_pkg::BFI_SZ_NONE)
      begin
         st_nxt.done = 1'b1;
         if (req_in.dst_literal)
         begin
            st_nxt.illegal    = 1'b1;
            st_nxt.res.result = req_in.dst;
         end
         else
         begin
            st_nxt.res.result = merged;
            st_nxt.res.flag_n = merged[size_msb(req_sz)];
            st_nxt.res.flag_z = (merged & size_mask(req_sz)) == 32'h0;
            st_nxt.res.flag_c = 1'b0;
            st_nxt.res.flag_v = (req_sz != bfi_pkg::BFI_SZ_WORD)
                                && (fld_end > size_bits(req_sz));
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign res_out     = st_r.res;
   assign done_out    = st_r.done;
   assign illegal_out = st_r.illegal;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_legal_req;
      req_valid_in && !req_in.dst_literal && req_sz != bfi_pkg::BFI_SZ_NONE;
   endsequence

   sequence s_word_req;
      s_legal_req ##0 req_sz == bfi_pkg::BFI_SZ_WORD;
   endsequence

   byte_decode_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      req_valid_in && req_in.opcode == `BFI_OP_BYTE |=> done_out)
      else $error("Byte opcode not answered");

   word_msb_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      s_word_req |=> res_out.flag_n == res_out.result[31] && !res_out.flag_v)
      else $error("Word N or V wrong");

   field_lsb_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      s_word_req |=> res_out.result[$past(fld_o)] == $past(req_in.src[0]))
      else $error("Field bit 0 misplaced");

   illegal_op_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      req_valid_in && req_sz != bfi_pkg::BFI_SZ_NONE && req_in.dst_literal
      |=> illegal_out && done_out && res_out.result == $past(req_in.dst))
      else $error("Literal destination not refused");

   carry_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      s_legal_req |=> !res_out.flag_c
      && res_out.flag_z == ((res_out.result & size_mask($past(req_sz))) == 32'h0))
      else $error("C or Z wrong");

   high_ignore_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      s_word_req
      |=> res_out.result[$past(req_in.offset[`BFI_SEL_W-1:0] + req_in.width[`BFI_SEL_W-1:0])]
      == $past(req_in.src[req_in.width[`BFI_SEL_W-1:0]]))
      else $error("Field top bit misplaced");

   keep_outside_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      s_legal_req |=> ((res_out.result ^ $past(req_in.dst)) & ~$past(fld_mask)) == 32'h0)
      else $error("Bit outside field changed");

   short_dst_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      s_legal_req ##0 req_sz != bfi_pkg::BFI_SZ_WORD
      |=> ((res_out.result ^ $past(req_in.dst)) & ~size_mask($past(req_sz))) == 32'h0
      && res_out.flag_v == ($past(fld_end) > size_bits($past(req_sz))))
      else $error("Short destination overrun wrong");

   half_decode_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      s_legal_req ##0 req_in.opcode == HALF_OPCODE
      |=> res_out.flag_n == res_out.result[15])
      else $error("Halfword N wrong");

endmodule : bfi_insert_unit

`default_nettype wire

//--- testbench/bfi_decode_model.sv
// Purpose : Decode side model feeding the insert unit
// Assumes : Requests launched on a rising edge
// Notes   : One request per call, valid for one cycle
`timescale 1ns/1ps
`default_nettype none

module bfi_decode_model (
   input  wire logic       clk_sys_in,
   output var  logic       req_valid_out,
   output var  bfi_pkg::bfi_req_t req_out
);
   initial req_valid_out = 1'b0;
   initial req_out = '0;

   // ----------------------------------------
   // Request launch
   // ----------------------------------------
   task automatic issue(input bfi_pkg::bfi_req_t rq);
      @(posedge clk_sys_in);
      req_valid_out <= 1'b1;
      req_out       <= rq;
      @(posedge clk_sys_in);
      req_valid_out <= 1'b0;
      req_out       <= ~rq;
   endtask : issue
endmodule : bfi_decode_model

`default_nettype wire

//--- testbench/bit_field_insert_unit_test.sv
// Purpose : Self-checking bench for the insert unit
// Assumes : One request at a time, answer one cycle later
// Notes   : Expectations built from field arithmetic
`timescale 1ns/1ps
`include "bfi_cfg.svh"
`default_nettype none

module bit_field_insert_unit_test;
   logic              clk_sys_in = 1'b0;
   logic              rst_n_in   = 1'b0;
   logic              vld;
   bfi_pkg::bfi_req_t rq;
   bfi_pkg::bfi_res_t res;
   logic              done;
   logic              ill;
   logic [3:0]        flags_keep;
   int                err_total = 0;
   int                compares  = 0;

   always #2 clk_sys_in = ~clk_sys_in;

   bfi_decode_model dec_u (.clk_sys_in(clk_sys_in), .req_valid_out(vld), .req_out(rq));
   bfi_insert_unit dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_valid_in(vld),
      .req_in(rq), .res_out(res), .done_out(done), .illegal_out(ill));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check

   function automatic bfi_pkg::bfi_res_t calc(input bfi_pkg::bfi_req_t q);
      bfi_pkg::bfi_res_t r;
      int sz;
      int p;
      sz = (q.opcode == `BFI_OP_BYTE) ? 8 : (q.opcode == `BFI_OP_WORD) ? 32 : 16;
      r = '0;
      r.result = q.dst;
      for (int i = 0; i <= int'(q.width[4:0]); i++)
      begin
         p = int'(q.offset[4:0]) + i;
         if ((p % 32) < sz)
            r.result[p % 32] = q.src[i];
      end
      r.flag_n = r.result[sz-1];
      r.flag_z = ((64'(r.result) & ((64'h1 << sz) - 64'h1)) == 64'h0);
      r.flag_v = (sz < 32) && (int'(q.width[4:0]) + int'(q.offset[4:0]) + 1 > sz);
      return r;
   endfunction : calc

   task automatic run_op(input string nm, input logic [7:0] op, input logic [31:0] w, off,
                         src, dst, lit);
      bfi_pkg::bfi_req_t q;
      bfi_pkg::bfi_res_t e;
      q = '{op, w, off, src, dst, 1'b0};
      e = calc(q);
      dec_u.issue(q);
      #1;
      check({nm, " done"}, 32'(done), 32'h1);
      check({nm, " illegal"}, 32'(ill), 32'h0);
      check({nm, " result"}, res.result, e.result);
      check({nm, " fixed"}, res.result, lit);
      check({nm, " flags"}, 32'({res.flag_n, res.flag_z, res.flag_c, res.flag_v}),
            32'({e.flag_n, e.flag_z, 1'b0, e.flag_v}));
      flags_keep = {res.flag_n, res.flag_z, res.flag_c, res.flag_v};
   endtask : run_op

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic s_word;
      run_op("word", 8'hc8, 32'hb, 32'h8, 32'h567, 32'habcdef01, 32'habc56701);
   endtask : s_word

   task automatic s_wrap;
      run_op("wrap", 8'hc8, 32'hffffffe7, 32'h3c, 32'ha5, 32'h0, 32'h5000000a);
   endtask : s_wrap

   task automatic s_byte;
      run_op("byte", 8'hcb, 32'h3, 32'h6, 32'hf, 32'h12345600, 32'h123456c0);
   endtask : s_byte

   task automatic s_half;
      run_op("half", 8'hca, 32'hf, 32'h0, 32'h0, 32'hffffffff, 32'hffff0000);
   endtask : s_half

   task automatic s_literal;
      dec_u.issue('{8'hc8, 32'h3, 32'h0, 32'hf, 32'h00000080, 1'b1});
      #1;
      check("lit done", 32'({done, ill}), 32'h3);
      check("lit result", res.result, 32'h00000080);
      check("lit flags", 32'({res.flag_n, res.flag_z, res.flag_c, res.flag_v}),
            32'(flags_keep));
   endtask : s_literal

   task automatic s_unknown;
      dec_u.issue('{8'hcc, 32'h3, 32'h0, 32'hf, 32'h0, 1'b0});
      #1;
      check("unknown done", 32'(done), 32'h0);
      check("unknown result", res.result, 32'h00000080);
   endtask : s_unknown

   task automatic s_reset;
      @(posedge clk_sys_in);
      rst_n_in <= 1'b0;
      #1;
      check("reset result", res.result, 32'h0);
      check("reset flags", 32'({res.flag_n, res.flag_z, res.flag_c, res.flag_v}), 32'h0);
      check("reset pulses", 32'({done, ill}), 32'h0);
      repeat (2) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      #1;
      check("reset held", res.result, 32'h0);
      check("reset idle", 32'(done), 32'h0);
   endtask : s_reset

   task automatic report_and_stop;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   initial
   begin
      repeat (20) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      s_word();
      s_wrap();
      s_byte();
      s_half();
      s_literal();
      s_unknown();
      s_reset();
      s_word();
      report_and_stop();
   end

   initial
   begin
      #10000;
      err_total++;
      report_and_stop();
   end
endmodule : bit_field_insert_unit_test

`default_nettype wire
